/* pwlm_pkg.sv */
// pwlm_pkg: shared constants for the piecewise linear mapper
`default_nettype none
package pwlm_pkg;
    localparam int NINST = 2;                       // number of mapper instances
    localparam int NPT   = 11;                      // breakpoints per instance
    localparam int NSRC  = 8;                       // selectable source signals
    localparam logic [15:0] FULL_SCALE = 16'hffff;  // normalized 1.0
    // word indices, byte address = 4 * index, instance select at byte address bit 6
    localparam logic [3:0] W_CTRL  = 4'h0;
    localparam logic [3:0] W_STATE = 4'h1;
    localparam logic [3:0] W_BDLY  = 4'h2;
    localparam logic [3:0] W_BOOST = 4'h3;
    localparam logic [3:0] W_PT0   = 4'h4;          // points 0..10 at 4'h4..4'he
    localparam logic [3:0] W_STAT  = 4'hf;
    localparam int INST_BIT = 6;
    localparam int MAP_TOP  = 7;                    // byte address bits 31:7 must be zero
    // field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_INV_BIT = 8;
    localparam int PT_X_LSB     = 0;
    localparam int PT_Y_LSB     = 16;
    localparam int STAT_BST_BIT = 16;
    // reset values
    localparam logic [3:0]  SEL_RST   = 4'h0;       // unconnected
    localparam logic        INV_RST   = 1'b0;
    localparam logic [10:0] ST_RST    = 11'h401;    // points 0 and 10 always on
    localparam logic [13:0] BDLY_RST  = 14'h0000;
    localparam logic [15:0] Y_RST     = 16'h0000;
    localparam logic [13:0] BDLY_MAX  = 14'h2710;   // 10000 ms
    localparam logic [10:0][15:0] PX_RST = {
        16'hffff, 16'he665, 16'hcccc, 16'hb332, 16'h9999, 16'h7fff,
        16'h6666, 16'h4ccc, 16'h3333, 16'h1999, 16'h0000};
    // timing
    localparam int CLK_NS = 20;
    localparam int MS_NS  = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;         // cycles per millisecond tick
    localparam int DIV_STEPS = 16;
    typedef enum logic [1:0] {
        PWLM_IDLE = 2'b01,
        PWLM_DIV  = 2'b10
    } pwlm_fsm_t;
endpackage
`default_nettype wire

/* pwlm_top.sv */
// pwlm_top: two piecewise linear curve mappers with an ahb-lite register file
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - two independent mappers, separate config and state
// - one normalized input, one normalized output each
// - curve built from up to eleven breakpoints
// - each point holds state, input, output coordinate
// - inactive points are skipped by segment search
// - output interpolated linearly between active neighbours
// - optional input inversion, off by default
// - source selectable or unconnected, unconnected by default
// - end points always on, fixed input coordinates
// - last point carries separate boost output value
// - nonzero delay exceeded at full scale gives boost
// - leaving full scale restarts boost timing
// - middle point states writable, reset to off

////////////////////////////////////////////////////////////////////////////////
module pwlm_curve (
    input  wire logic              sys_clk_in,
    input  wire logic              reset_in,
    input  wire logic              ms_tick_in,
    input  wire logic [15:0]       x_raw_in,
    input  wire logic              invert_in,
    input  wire logic [10:0]       state_in,
    input  wire logic [10:0][15:0] px_in,
    input  wire logic [10:0][15:0] py_in,
    input  wire logic [13:0]       delay_in,
    input  wire logic [15:0]       boost_y_in,
    output logic      [15:0]       y_out,
    output logic                   boost_out
);
    pwlm_pkg::pwlm_fsm_t fsm_q;
    logic [15:0] xn;
    logic        full;
    logic [10:0] st_eff;
    logic [3:0]  lo;
    logic [3:0]  hi;
    logic [15:0] dx_seg;
    logic [15:0] dy_abs;
    logic [31:0] num;
    logic [16:0] rem_q;
    logic [15:0] nlo_q;
    logic [15:0] den_q;
    logic [15:0] quo_q;
    logic [15:0] ybase_q;
    logic        neg_q;
    logic [4:0]  step_q;
    logic [16:0] trial;
    logic        qbit;
    logic [15:0] qn;
    logic [13:0] hold_q;
    logic [15:0] y_q;
    logic        boost_q;

    // input conditioning and full scale detect
    assign xn     = invert_in ? ~x_raw_in : x_raw_in;
    assign full   = (xn == pwlm_pkg::FULL_SCALE);
    assign st_eff = state_in | pwlm_pkg::ST_RST;

    // segment search over active points only
    always_comb begin
        lo = 4'h0;
        hi = 4'ha;
        for (int i = 0; i < pwlm_pkg::NPT; i++) begin
            if (st_eff[i] && (px_in[i] <= xn)) begin
                lo = 4'(i);
            end
        end
        for (int i = pwlm_pkg::NPT - 1; i >= 0; i--) begin
            if (st_eff[i] && (4'(i) > lo)) begin
                hi = 4'(i);
            end
        end
    end

    // segment geometry for slope and intercept
    assign dx_seg = px_in[hi] - px_in[lo];
    assign dy_abs = (py_in[hi] >= py_in[lo]) ? (py_in[hi] - py_in[lo])
                                             : (py_in[lo] - py_in[hi]);
    assign num    = {16'h0000, dy_abs} * {16'h0000, xn - px_in[lo]};

    // one restoring division step
    assign trial = {rem_q[15:0], nlo_q[15]};
    assign qbit  = (trial >= {1'b0, den_q});
    assign qn    = {quo_q[14:0], qbit};

    // controller: start a segment evaluation or finish the division
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fsm_q   <= pwlm_pkg::PWLM_IDLE;
            y_q     <= pwlm_pkg::Y_RST;
            rem_q   <= 17'h00000;
            nlo_q   <= 16'h0000;
            den_q   <= 16'h0000;
            quo_q   <= 16'h0000;
            ybase_q <= 16'h0000;
            neg_q   <= 1'b0;
            step_q  <= 5'h00;
        end else begin
            case (fsm_q)
                pwlm_pkg::PWLM_IDLE: begin
                    if (boost_q) begin
                        y_q <= boost_y_in;
                    end else if ((lo == hi) || (dx_seg == 16'h0000)) begin
                        y_q <= py_in[lo];
                    end else begin
                        rem_q   <= {1'b0, num[31:16]};
                        nlo_q   <= num[15:0];
                        den_q   <= dx_seg;
                        quo_q   <= 16'h0000;
                        ybase_q <= py_in[lo];
                        neg_q   <= (py_in[hi] < py_in[lo]);
                        step_q  <= 5'h00;
                        fsm_q   <= pwlm_pkg::PWLM_DIV;
                    end
                end
                pwlm_pkg::PWLM_DIV: begin
                    rem_q  <= qbit ? (trial - {1'b0, den_q}) : trial;
                    nlo_q  <= {nlo_q[14:0], 1'b0};
                    quo_q  <= qn;
                    step_q <= step_q + 5'h01;
                    if (step_q == 5'(pwlm_pkg::DIV_STEPS - 1)) begin
                        y_q   <= neg_q ? (ybase_q - qn) : (ybase_q + qn);
                        fsm_q <= pwlm_pkg::PWLM_IDLE;
                    end
                end
                default: begin
                    fsm_q <= pwlm_pkg::PWLM_IDLE;
                end
            endcase
        end
    end

    // boost timer: counts ms ticks while the input sits at full scale
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hold_q  <= 14'h0000;
            boost_q <= 1'b0;
        end else begin
            if (!full) begin
                hold_q <= 14'h0000;
            end else if (ms_tick_in && (hold_q <= delay_in)) begin
                hold_q <= hold_q + 14'h0001;
            end
            boost_q <= (delay_in != 14'h0000) && full && (hold_q > delay_in);
        end
    end

    assign y_out     = y_q;
    assign boost_out = boost_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    chk_boost_zero_dly: assert property ((delay_in == 14'h0000) |=> !boost_out)
        else $error("boost active with zero delay");
    chk_boost_leave_full: assert property (!full |=> !boost_out && hold_q == 14'h0000)
        else $error("boost timing not restarted");
    chk_boost_value: assert property ((boost_q && fsm_q == pwlm_pkg::PWLM_IDLE)
        |=> y_out == $past(boost_y_in))
        else $error("boost value not driven");
    chk_full_end_point: assert property ((fsm_q == pwlm_pkg::PWLM_IDLE && !boost_q && full)
        |=> y_out == $past(py_in[10]))
        else $error("full scale not mapped to last point");
    chk_div_length: assert property ((fsm_q == pwlm_pkg::PWLM_DIV && step_q == 5'h00)
        |-> (fsm_q == pwlm_pkg::PWLM_DIV)[*8] ##1 (fsm_q == pwlm_pkg::PWLM_DIV)[*8]
        ##1 fsm_q == pwlm_pkg::PWLM_IDLE)
        else $error("interpolation length wrong");
    chk_seg_active: assert property ((fsm_q == pwlm_pkg::PWLM_IDLE)
        |-> st_eff[lo] && st_eff[hi] && lo <= hi)
        else $error("segment uses inactive point");
endmodule // pwlm_curve

////////////////////////////////////////////////////////////////////////////////
module pwlm_top #(
    parameter int unsigned MS_CYCLES = pwlm_pkg::MS_CYC
) (
    input  wire logic                       sys_clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       hsel_in,
    input  wire logic [31:0]                haddr_in,
    input  wire logic [1:0]                 htrans_in,
    input  wire logic                       hwrite_in,
    input  wire logic [2:0]                 hsize_in,
    input  wire logic [31:0]                hwdata_in,
    input  wire logic                       hready_in,
    input  wire logic [7:0][15:0]           src_bus_in,
    output logic      [31:0]                hrdata_out,
    output logic                            hreadyout_out,
    output logic                            hresp_out,
    output logic      [1:0][15:0]           norm_output_out,
    output logic      [1:0]                 boost_out
);
    logic [1:0][3:0]        sel_q;
    logic [1:0]             inv_q;
    logic [1:0][10:0]       st_q;
    logic [1:0][10:0][15:0] px_q;
    logic [1:0][10:0][15:0] py_q;
    logic [1:0][13:0]       dly_q;
    logic [1:0][15:0]       by_q;
    logic [1:0][15:0]       norm_input;
    logic [15:0]            ms_cnt_q;
    logic                   tick_q;
    logic                   acc;
    logic                   wr_q;
    logic                   rd_q;
    logic                   map_q;
    logic                   inst_q;
    logic [3:0]             widx_q;
    logic [31:0]            hrdata_q;
    logic                   rdy_q;
    logic                   hresp_q;

    // point index of a word address, 4'hf when not a point word
    function automatic logic [3:0] pt_of(input logic [3:0] w);
        pt_of = ((w >= pwlm_pkg::W_PT0) && (w < pwlm_pkg::W_STAT)) ? (w - pwlm_pkg::W_PT0)
                                                                   : 4'hf;
    endfunction

    // keeps a value between two limits
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick divider
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ms_cnt_q <= 16'h0000;
            tick_q   <= 1'b0;
        end else if (ms_cnt_q == 16'(MS_CYCLES - 1)) begin
            ms_cnt_q <= 16'h0000;
            tick_q   <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
            tick_q   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture, reads take one wait state
    assign acc = hsel_in && htrans_in[1] && hready_in;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            map_q   <= 1'b0;
            inst_q  <= 1'b0;
            widx_q  <= 4'h0;
            rdy_q   <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            wr_q  <= acc && hwrite_in;
            rd_q  <= acc && !hwrite_in;
            rdy_q <= !(acc && !hwrite_in);
            if (acc) begin
                map_q  <= (haddr_in[31:pwlm_pkg::MAP_TOP] == '0);
                inst_q <= haddr_in[pwlm_pkg::INST_BIT];
                widx_q <= haddr_in[5:2];
            end
        end
    end

    // read data, sampled after any write of the previous transfer has landed
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_q) begin
            hrdata_q <= 32'h00000000;
            if (map_q) begin
                case (widx_q)
                    pwlm_pkg::W_CTRL:  begin
                        hrdata_q[pwlm_pkg::CTRL_SEL_LSB +: 4] <= sel_q[inst_q];
                        hrdata_q[pwlm_pkg::CTRL_INV_BIT]      <= inv_q[inst_q];
                    end
                    pwlm_pkg::W_STATE: hrdata_q[10:0] <= st_q[inst_q];
                    pwlm_pkg::W_BDLY:  hrdata_q[13:0] <= dly_q[inst_q];
                    pwlm_pkg::W_BOOST: hrdata_q[15:0] <= by_q[inst_q];
                    pwlm_pkg::W_STAT:  begin
                        hrdata_q[15:0] <= norm_output_out[inst_q];
                        hrdata_q[pwlm_pkg::STAT_BST_BIT] <= boost_out[inst_q];
                    end
                    default: begin
                        hrdata_q[pwlm_pkg::PT_X_LSB +: 16] <= px_q[inst_q][pt_of(widx_q)];
                        hrdata_q[pwlm_pkg::PT_Y_LSB +: 16] <= py_q[inst_q][pt_of(widx_q)];
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration writes in the data phase
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int k = 0; k < pwlm_pkg::NINST; k++) begin
                sel_q[k] <= pwlm_pkg::SEL_RST;
                inv_q[k] <= pwlm_pkg::INV_RST;
                st_q[k]  <= pwlm_pkg::ST_RST;
                px_q[k]  <= pwlm_pkg::PX_RST;
                py_q[k]  <= '0;
                dly_q[k] <= pwlm_pkg::BDLY_RST;
                by_q[k]  <= pwlm_pkg::Y_RST;
            end
        end else if (wr_q && map_q) begin
            case (widx_q)
                pwlm_pkg::W_CTRL: begin
                    sel_q[inst_q] <= hwdata_in[pwlm_pkg::CTRL_SEL_LSB +: 4];
                    inv_q[inst_q] <= hwdata_in[pwlm_pkg::CTRL_INV_BIT];
                end
                pwlm_pkg::W_STATE: st_q[inst_q] <= hwdata_in[10:0] | pwlm_pkg::ST_RST;
                pwlm_pkg::W_BDLY: begin
                    dly_q[inst_q] <= (hwdata_in > {18'h0, pwlm_pkg::BDLY_MAX})
                                     ? pwlm_pkg::BDLY_MAX : hwdata_in[13:0];
                end
                pwlm_pkg::W_BOOST: by_q[inst_q] <= hwdata_in[15:0];
                pwlm_pkg::W_STAT: begin end            // status word is read only
                default: begin
                    py_q[inst_q][pt_of(widx_q)] <= hwdata_in[pwlm_pkg::PT_Y_LSB +: 16];
                    if ((pt_of(widx_q) != 4'h0) && (pt_of(widx_q) != 4'ha)) begin
                        px_q[inst_q][pt_of(widx_q)] <= clamp(
                            hwdata_in[pwlm_pkg::PT_X_LSB +: 16],
                            px_q[inst_q][pt_of(widx_q) - 4'h1],
                            px_q[inst_q][pt_of(widx_q) + 4'h1]);
                    end
                end
            endcase
        end
    end

    assign hrdata_out    = hrdata_q;
    assign hreadyout_out = rdy_q;
    assign hresp_out     = hresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // per instance source select and curve
    for (genvar g = 0; g < pwlm_pkg::NINST; g++) begin : g_inst
        assign norm_input[g] = ((sel_q[g] == 4'h0) || (sel_q[g] > 4'(pwlm_pkg::NSRC)))
                               ? 16'h0000 : src_bus_in[sel_q[g] - 4'h1];
        pwlm_curve u_curve (
            .sys_clk_in (sys_clk_in),
            .reset_in   (reset_in),
            .ms_tick_in (tick_q),
            .x_raw_in   (norm_input[g]),
            .invert_in  (inv_q[g]),
            .state_in   (st_q[g]),
            .px_in      (px_q[g]),
            .py_in      (py_q[g]),
            .delay_in   (dly_q[g]),
            .boost_y_in (by_q[g]),
            .y_out      (norm_output_out[g]),
            .boost_out  (boost_out[g])
        );
        chk_pt_order: assert property (@(posedge sys_clk_in) disable iff (reset_in)
            (px_q[g][0] == 16'h0000) && (px_q[g][10] == pwlm_pkg::FULL_SCALE)
            && (px_q[g][4] <= px_q[g][5]) && (px_q[g][5] <= px_q[g][6]))
            else $error("point coordinates out of order");
    end
    chk_read_wait: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (acc && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    chk_dly_limit: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (dly_q[0] <= pwlm_pkg::BDLY_MAX) && (dly_q[1] <= pwlm_pkg::BDLY_MAX))
        else $error("boost delay above limit");
endmodule // pwlm_top
`default_nettype wire

/* pwlm_src_model.sv */
// pwlm_src_model: behavioural model of the function blocks that feed the mapper sources
`timescale 1ns/100ps
`default_nettype none
module pwlm_src_model (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_in,
    input  wire logic [7:0][15:0] level_in,
    output logic      [7:0][15:0] src_out
);
    // each source block publishes one normalized value per clock, zero while in reset
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            src_out <= '0;
        end else begin
            src_out <= level_in;
        end
    end
endmodule // pwlm_src_model
`default_nettype wire

/* pwlm_tb.sv */
// pwlm_tb: self-checking testbench for the two curve mappers
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int MSC = 20;
    localparam int LIMIT = 20000;
    logic                sys_clk = 1'b0;
    logic                reset = 1'b1;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [2:0]          hsize = 3'h0;
    logic [31:0]         hwdata = 32'h0;
    logic [7:0][15:0]    level = '0;
    wire logic [7:0][15:0] src;
    wire logic [31:0]    hrdata_out;
    wire logic           hready_bus;
    wire logic           hresp_out;
    wire logic [1:0][15:0] norm_output_out;
    wire logic [1:0]     boost_out;
    int                  failures = 0;
    int                  checks_done = 0;
    int                  cycles = 0;
    logic [10:0]         st [2];
    logic [10:0][15:0]   py [2];
    logic                inv [2];

    ////////////////////////////////////////////////////////////////////////////
    // clock, partner and design
    always #10 sys_clk = ~sys_clk;
    pwlm_src_model src_m (.sys_clk_in(sys_clk), .reset_in(reset), .level_in(level), .src_out(src));
    pwlm_top #(.MS_CYCLES(MSC)) uut (
        .sys_clk_in(sys_clk), .reset_in(reset), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready_bus), .src_bus_in(src), .hrdata_out(hrdata_out),
        .hreadyout_out(hready_bus), .hresp_out(hresp_out),
        .norm_output_out(norm_output_out), .boost_out(boost_out));

    ////////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bus tasks
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // single transfer; master holds each phase until hready is sampled high
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hready_bus !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready_bus !== 1'b1);
        r = hrdata_out;
        chk_val({31'h0, hresp_out}, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(a, 1'b1, d, r);
    endtask
    task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(a, 1'b0, 32'h0, r);
        chk_val(r, exp);
    endtask
    // expected curve output: highest active point at or below x, next active point above
    function automatic logic [15:0] f_exp(input logic [15:0] x, input logic [10:0] s,
                                          input logic [10:0][15:0] y);
        int lo;
        int hi;
        logic [31:0] dx;
        logic [31:0] w;
        lo = 0;
        hi = 10;
        for (int i = 0; i < 11; i++) if (s[i] && pwlm_pkg::PX_RST[i] <= x) lo = i;
        for (int i = 10; i > lo; i--) if (s[i]) hi = i;
        if (lo == 10 || pwlm_pkg::PX_RST[lo] == x) return y[lo];
        dx = 32'(x - pwlm_pkg::PX_RST[lo]);
        w = 32'(pwlm_pkg::PX_RST[hi] - pwlm_pkg::PX_RST[lo]);
        if (y[hi] >= y[lo]) return y[lo] + 16'((32'(y[hi] - y[lo]) * dx) / w);
        return y[lo] - 16'((32'(y[lo] - y[hi]) * dx) / w);
    endfunction
    // random curve on one instance, corner inputs first, then random ones
    task automatic curve_test(input int k);
        logic [31:0] b;
        logic [15:0] xs;
        logic [15:0] e;
        b = 32'(k) << 6;
        inv[k] = 1'($urandom);
        st[k] = {1'b1, 9'($urandom), 1'b1};
        wr(b, {23'h0, inv[k], 4'h0, 4'(k + 1)});
        wr(b + 32'h4, {21'h0, st[k]});
        for (int i = 0; i < 11; i++) begin
            py[k][i] = 16'($urandom);
            wr(b + 32'h10 + 32'(4 * i), {py[k][i], pwlm_pkg::PX_RST[i]});
        end
        chk_rd(b + 32'h4, {21'h0, st[k]});
        for (int n = 0; n < 14; n++) begin
            xs = (n == 0) ? 16'h0 : (n == 1) ? 16'hffff : (n == 2) ? 16'h4ccc : 16'($urandom);
            level[k] <= xs;
            e = f_exp(inv[k] ? ~xs : xs, st[k], py[k]);
            repeat (40) @(posedge sys_clk);
            chk_val({16'h0, norm_output_out[k]}, {16'h0, e});
            chk_rd(b + 32'h3c, {16'h0, e});
        end
        $display("test curve %0d done", k);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'h4d1c9dd7));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        chk_rd(32'h0, 32'h0);
        chk_rd(32'h4, 32'h401);
        chk_rd(32'h44, 32'h401);
        chk_rd(32'h8, 32'h0);
        chk_rd(32'hc, 32'h0);
        for (int i = 0; i < 11; i++) begin
            chk_rd(32'h10 + 32'(4 * i), {16'h0, pwlm_pkg::PX_RST[i]});
        end
        chk_val({16'h0, norm_output_out[0]}, 32'h0);
        wr(32'h80, 32'h1);
        chk_rd(32'h80, 32'h0);
        wr(32'h4, 32'h0);
        chk_rd(32'h4, 32'h401);
        wr(32'h10, 32'h0000_5678);
        chk_rd(32'h10, 32'h0);
        wr(32'h38, 32'h0000_1234);
        chk_rd(32'h38, 32'h0000_ffff);
        wr(32'h24, 32'h0000_ffff);
        chk_rd(32'h24, 32'h0000_9999);
        wr(32'h24, 32'h0000_0000);
        chk_rd(32'h24, 32'h0000_6666);
        wr(32'h8, 32'h0000_3fff);
        chk_rd(32'h8, 32'h0000_2710);
        wr(32'h8, 32'h0);
        $display("test registers done");
        curve_test(0);
        curve_test(1);
        chk_val({16'h0, norm_output_out[0]},
                {16'h0, f_exp(inv[0] ? ~level[0] : level[0], st[0], py[0])});
        wr(32'h0, 32'h9);
        repeat (40) @(posedge sys_clk);
        chk_val({16'h0, norm_output_out[0]}, {16'h0, f_exp(16'h0, st[0], py[0])});
        // boost: 3 ms delay, full scale held
        wr(32'h0, 32'h1);
        wr(32'h8, 32'h3);
        wr(32'hc, 32'h1234);
        level[0] <= 16'hffff;
        repeat (55) @(posedge sys_clk);
        chk_val({30'h0, boost_out}, 32'h0);
        for (int n = 0; n < 40 && boost_out[0] !== 1'b1; n++) @(posedge sys_clk);
        @(posedge sys_clk);
        chk_val({16'h0, norm_output_out[0]}, 32'h1234);
        chk_rd(32'h3c, 32'h0001_1234);
        level[0] <= 16'hfffe;
        repeat (4) @(posedge sys_clk);
        chk_val({31'h0, boost_out[0]}, 32'h0);
        level[0] <= 16'hffff;
        repeat (55) @(posedge sys_clk);
        chk_val({31'h0, boost_out[0]}, 32'h0);
        wr(32'h8, 32'h0);
        repeat (200) @(posedge sys_clk);
        chk_val({31'h0, boost_out[0]}, 32'h0);
        chk_val({16'h0, norm_output_out[0]}, {16'h0, py[0][10]});
        $display("test boost done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
